// File: core/hmc_pkg.sv
package hmc_pkg;

	// command codes
	localparam logic [7:0] CMD_WRITE = 8'h18;
	localparam logic [7:0] CMD_CTRL_RD = 8'h68;
	localparam logic [7:0] CMD_CTRL_WR = 8'h78;

	// write length limits
	localparam logic [7:0] LEN_MIN = 8'h01;
	localparam logic [7:0] LEN_MAX = 8'hFB;

	// command result codes
	localparam logic [3:0] RES_NONE = 4'h0;
	localparam logic [3:0] RES_OK = 4'h5;
	localparam logic [3:0] RES_UNIMPL = 4'h8;
	localparam logic [3:0] RES_PARAM = 4'hA;
	localparam logic [3:0] RES_BUSY = 4'h7;

	// control byte fields
	localparam int CTL_MASK_LSB = 4;
	localparam int CTL_RF_STOP_BIT = 3;
	localparam int CTL_RSV_BIT = 2;
	localparam int CTL_CFG_ERR_BIT = 1;
	localparam int CTL_BCC_ERR_BIT = 0;
	localparam int CTL_SRST_BIT = 0;
	localparam logic [3:0] MASK_RESET = 4'h0;
	localparam logic RF_STOP_RESET = 1'b0;

	// status byte fields
	localparam int STAT_FLAG_LSB = 4;
	localparam int STAT_RES_LSB = 0;

	// byte shown on the link when nothing is left to send
	localparam logic [7:0] TX_IDLE = 8'hFF;

	// self-reset time, least 3 ms, rounded up to clock cycles
	localparam int CLK_HZ = 25000000;
	localparam int SRST_TIME_MS = 3;
	localparam int SRST_CYCLES = (SRST_TIME_MS * CLK_HZ + 999) / 1000;

	// command decoder states
	typedef enum logic [6:0] {
		ST_CMD = 7'b0000001,
		ST_ADDR_H = 7'b0000010,
		ST_ADDR_L = 7'b0000100,
		ST_LEN = 7'b0001000,
		ST_DATA = 7'b0010000,
		ST_CTL = 7'b0100000,
		ST_SRST = 7'b1000000
	} hmc_state_e;

endpackage : hmc_pkg

// File: core/hmc_tog_sync.sv
// carries a toggle from the link domain and turns each change into one pulse
module hmc_tog_sync (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// toggle from the other domain
	input wire logic tog,
	// one-cycle pulse per toggle change
	output logic pulse
);

	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic pulse_r;

	// two-stage synchroniser, then edge detect on the second stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			pulse_r <= 1'b0;
		end else begin
			s1_r <= tog;
			s2_r <= s1_r;
			s3_r <= s2_r;
			pulse_r <= s2_r ^ s3_r;
		end
	end

	assign pulse = pulse_r;

endmodule : hmc_tog_sync

// File: core/hmc_host_cmd.sv
//Behaviour
//- write command is 0x18, address high then low, length, then payload bytes.
//- control-read is code 0x68 alone; reply is status then control byte.
//- control-read bits 7..3 return masks and rf-stop as last written.
//- control-read bit 1 reports the configuration-enable check error.
//- control-read bit 0 reports the block-check-character error.
//- control-write is code 0x78 plus one data byte; reply is one status.
//- bit 7 set suppresses the rf memory-write interrupt flag.
//- bit 6 set suppresses the rf memory-read interrupt flag.
//- bit 5 set suppresses the rf transmission-done interrupt flag.
//- bit 4 set suppresses the field-detect interrupt flag.
//- bit 3 set stops all rf communication while set.
//- reset-request bit 0 triggers self-reset only after the reply is sent.
//- self-reset reloads internal settings from nonvolatile memory.
//- access during self-reset gets a busy answer.
//- a status read returns the current status byte.
//- status holds four pending flags in bits 7..4 and result in 3..0.
//- results: 0x5 ok, 0x8 unknown, 0xA bad parameter, 0x7 busy.
//- a slave-transmission request acts as status command.
//- interrupt output goes low when done, released on read address.
module hmc_host_cmd #(
	parameter int SRST_CYCLES = hmc_pkg::SRST_CYCLES
) (
	// core clock and reset
	input wire logic clk,
	input wire logic rst,
	// link side, from the serial front end
	input wire logic link_clk,
	input wire logic lnk_rx_stb,
	input wire logic [7:0] lnk_rx_byte,
	input wire logic lnk_rd_req,
	input wire logic lnk_tx_ack,
	input wire logic lnk_stop,
	output logic [7:0] lnk_tx_byte,
	// rf event pulses and nonvolatile check results
	input wire logic rf_wr_evt,
	input wire logic rf_rd_evt,
	input wire logic rf_tx_evt,
	input wire logic fld_det_evt,
	input wire logic chk_cfg_err,
	input wire logic chk_bcc_err,
	// interrupt and rf control
	output logic irq_out_n,
	output logic [3:0] irq_mask,
	output logic rf_stop,
	output logic nvm_reload,
	// memory write port
	output logic mem_we,
	output logic [15:0] mem_addr,
	output logic [7:0] mem_wdata
);

	localparam int CW = $clog2(SRST_CYCLES + 1);

	// link domain state
	logic [7:0] rx_hold_r, rx_hold_nxt;
	logic rx_tog_r, rx_tog_nxt;
	logic rd_tog_r, rd_tog_nxt;
	logic stp_tog_r, stp_tog_nxt;
	logic [7:0] tx_byte_r, tx_byte_nxt;
	logic tx_sel_r, tx_sel_nxt;

	// core domain state
	hmc_pkg::hmc_state_e st_r, st_nxt;
	logic [15:0] addr_r, addr_nxt;
	logic [7:0] cnt_r, cnt_nxt;
	logic [3:0] mask_r, mask_nxt;
	logic rf_stop_r, rf_stop_nxt;
	logic srst_pend_r, srst_pend_nxt;
	logic [3:0] res_r, res_nxt;
	logic [3:0] flags_r, flags_nxt;
	logic irq_n_r, irq_n_nxt;
	logic rd_act_r, rd_act_nxt;
	logic [7:0] resp0_r, resp0_nxt;
	logic [7:0] resp1_r, resp1_nxt;
	logic resp_two_r, resp_two_nxt;
	logic [CW-1:0] srst_cnt_r, srst_cnt_nxt;
	logic cfg_err_r, cfg_err_nxt;
	logic bcc_err_r, bcc_err_nxt;
	logic mem_we_r, mem_we_nxt;
	logic [15:0] mem_addr_r, mem_addr_nxt;
	logic [7:0] mem_wdata_r, mem_wdata_nxt;
	logic nvm_reload_r, nvm_reload_nxt;

	logic [2:0] tog_vec;
	logic [2:0] evt_vec;
	logic rx_evt;
	logic rd_evt;
	logic stp_evt;
	logic [3:0] rf_evt;
	logic done;

	// control byte as returned to the host
	function automatic logic [7:0] ctl_byte(input logic [3:0] m, input logic s,
		input logic cfg, input logic bcc);
		logic [7:0] b;
		b = 8'h00;
		b[hmc_pkg::CTL_MASK_LSB +: 4] = m;
		b[hmc_pkg::CTL_RF_STOP_BIT] = s;
		b[hmc_pkg::CTL_RSV_BIT] = 1'b0;
		b[hmc_pkg::CTL_CFG_ERR_BIT] = cfg;
		b[hmc_pkg::CTL_BCC_ERR_BIT] = bcc;
		return b;
	endfunction : ctl_byte

	// link domain: capture bytes and events as toggles, serve reply bytes
	always_comb begin
		rx_hold_nxt = rx_hold_r;
		rx_tog_nxt = rx_tog_r ^ lnk_rx_stb;
		rd_tog_nxt = rd_tog_r ^ lnk_rd_req;
		stp_tog_nxt = stp_tog_r ^ lnk_stop;
		tx_byte_nxt = tx_byte_r;
		tx_sel_nxt = tx_sel_r;
		if (lnk_rx_stb) begin
			rx_hold_nxt = lnk_rx_byte;
		end
		if (lnk_rd_req) begin
			tx_byte_nxt = resp0_r;
			tx_sel_nxt = 1'b1;
		end else if (lnk_tx_ack) begin
			// second byte only while the last decoded command was a control read
			tx_byte_nxt = (tx_sel_r && resp_two_r) ? resp1_r : hmc_pkg::TX_IDLE;
			tx_sel_nxt = 1'b0;
		end
	end

	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			rx_hold_r <= 8'h00;
			rx_tog_r <= 1'b0;
			rd_tog_r <= 1'b0;
			stp_tog_r <= 1'b0;
			tx_byte_r <= hmc_pkg::TX_IDLE;
			tx_sel_r <= 1'b0;
		end else begin
			rx_hold_r <= rx_hold_nxt;
			rx_tog_r <= rx_tog_nxt;
			rd_tog_r <= rd_tog_nxt;
			stp_tog_r <= stp_tog_nxt;
			tx_byte_r <= tx_byte_nxt;
			tx_sel_r <= tx_sel_nxt;
		end
	end

	// event crossings into the core clock
	assign tog_vec = {stp_tog_r, rd_tog_r, rx_tog_r};
	generate
		for (genvar i = 0; i < 3; i++) begin : g_sync
			hmc_tog_sync u_sync (
				.clk(clk),
				.rst(rst),
				.tog(tog_vec[i]),
				.pulse(evt_vec[i])
			);
		end
	endgenerate

	assign rx_evt = evt_vec[0];
	assign rd_evt = evt_vec[1];
	assign stp_evt = evt_vec[2];
	assign rf_evt = {rf_wr_evt, rf_rd_evt, rf_tx_evt, fld_det_evt};

	// command decoder, flags, reply and self-reset
	always_comb begin
		st_nxt = st_r;
		addr_nxt = addr_r;
		cnt_nxt = cnt_r;
		mask_nxt = mask_r;
		rf_stop_nxt = rf_stop_r;
		srst_pend_nxt = srst_pend_r;
		res_nxt = res_r;
		irq_n_nxt = irq_n_r;
		rd_act_nxt = rd_act_r;
		resp1_nxt = resp1_r;
		resp_two_nxt = resp_two_r;
		srst_cnt_nxt = srst_cnt_r;
		cfg_err_nxt = cfg_err_r;
		bcc_err_nxt = bcc_err_r;
		mem_we_nxt = 1'b0;
		mem_addr_nxt = mem_addr_r;
		mem_wdata_nxt = mem_wdata_r;
		nvm_reload_nxt = 1'b0;
		done = 1'b0;
		// pending flags: cleared by a status read, a new event wins
		flags_nxt = rd_evt ? 4'h0 : flags_r;
		flags_nxt = flags_nxt | (rf_evt & ~mask_r);
		// read address recognised releases the interrupt
		if (rd_evt) begin
			irq_n_nxt = 1'b1;
			rd_act_nxt = 1'b1;
		end
		// stop ends a read; a requested self-reset starts after it
		if (stp_evt) begin
			rd_act_nxt = 1'b0;
			if (rd_act_r && srst_pend_r) begin
				st_nxt = hmc_pkg::ST_SRST;
				srst_cnt_nxt = '0;
				srst_pend_nxt = 1'b0;
				nvm_reload_nxt = 1'b1;
			end
		end
		unique case (st_r)
			hmc_pkg::ST_CMD: begin
				if (rx_evt) begin
					resp_two_nxt = 1'b0;
					if (rx_hold_r == hmc_pkg::CMD_WRITE) begin
						st_nxt = hmc_pkg::ST_ADDR_H;
					end else if (rx_hold_r == hmc_pkg::CMD_CTRL_RD) begin
						resp1_nxt = ctl_byte(mask_r, rf_stop_r, cfg_err_r, bcc_err_r);
						resp_two_nxt = 1'b1;
						res_nxt = hmc_pkg::RES_OK;
						done = 1'b1;
					end else if (rx_hold_r == hmc_pkg::CMD_CTRL_WR) begin
						st_nxt = hmc_pkg::ST_CTL;
					end else begin
						res_nxt = hmc_pkg::RES_UNIMPL;
						done = 1'b1;
					end
				end
			end
			hmc_pkg::ST_ADDR_H: begin
				if (rx_evt) begin
					addr_nxt = {rx_hold_r, addr_r[7:0]};
					st_nxt = hmc_pkg::ST_ADDR_L;
				end
			end
			hmc_pkg::ST_ADDR_L: begin
				if (rx_evt) begin
					addr_nxt = {addr_r[15:8], rx_hold_r};
					st_nxt = hmc_pkg::ST_LEN;
				end
			end
			hmc_pkg::ST_LEN: begin
				if (rx_evt) begin
					if (rx_hold_r < hmc_pkg::LEN_MIN || rx_hold_r > hmc_pkg::LEN_MAX) begin
						res_nxt = hmc_pkg::RES_PARAM;
						done = 1'b1;
						st_nxt = hmc_pkg::ST_CMD;
					end else begin
						cnt_nxt = rx_hold_r;
						st_nxt = hmc_pkg::ST_DATA;
					end
				end
			end
			hmc_pkg::ST_DATA: begin
				if (rx_evt) begin
					mem_we_nxt = 1'b1;
					mem_addr_nxt = addr_r;
					mem_wdata_nxt = rx_hold_r;
					addr_nxt = addr_r + 16'h0001;
					cnt_nxt = cnt_r - 8'h01;
					if (cnt_r == 8'h01) begin
						res_nxt = hmc_pkg::RES_OK;
						done = 1'b1;
						st_nxt = hmc_pkg::ST_CMD;
					end
				end
			end
			hmc_pkg::ST_CTL: begin
				if (rx_evt) begin
					mask_nxt = rx_hold_r[hmc_pkg::CTL_MASK_LSB +: 4];
					rf_stop_nxt = rx_hold_r[hmc_pkg::CTL_RF_STOP_BIT];
					srst_pend_nxt = rx_hold_r[hmc_pkg::CTL_SRST_BIT];
					res_nxt = hmc_pkg::RES_OK;
					done = 1'b1;
					st_nxt = hmc_pkg::ST_CMD;
				end
			end
			hmc_pkg::ST_SRST: begin
				// incoming bytes are dropped; status shows busy meanwhile
				srst_cnt_nxt = srst_cnt_r + CW'(1);
				if (srst_cnt_r == CW'(SRST_CYCLES - 1)) begin
					mask_nxt = hmc_pkg::MASK_RESET;
					rf_stop_nxt = hmc_pkg::RF_STOP_RESET;
					cfg_err_nxt = chk_cfg_err;
					bcc_err_nxt = chk_bcc_err;
					res_nxt = hmc_pkg::RES_NONE;
					st_nxt = hmc_pkg::ST_CMD;
				end
			end
		endcase
		if (done) begin
			irq_n_nxt = 1'b0;
		end
		// status byte frozen while the host reads it
		resp0_nxt = resp0_r;
		if (!rd_act_r) begin
			resp0_nxt[hmc_pkg::STAT_FLAG_LSB +: 4] = flags_r;
			resp0_nxt[hmc_pkg::STAT_RES_LSB +: 4] =
				(st_r == hmc_pkg::ST_SRST) ? hmc_pkg::RES_BUSY : res_r;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r <= hmc_pkg::ST_SRST;
			addr_r <= 16'h0000;
			cnt_r <= 8'h00;
			mask_r <= hmc_pkg::MASK_RESET;
			rf_stop_r <= hmc_pkg::RF_STOP_RESET;
			srst_pend_r <= 1'b0;
			res_r <= hmc_pkg::RES_NONE;
			flags_r <= 4'h0;
			irq_n_r <= 1'b1;
			rd_act_r <= 1'b0;
			resp0_r <= 8'h00;
			resp1_r <= 8'h00;
			resp_two_r <= 1'b0;
			srst_cnt_r <= '0;
			cfg_err_r <= 1'b0;
			bcc_err_r <= 1'b0;
			mem_we_r <= 1'b0;
			mem_addr_r <= 16'h0000;
			mem_wdata_r <= 8'h00;
			nvm_reload_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			addr_r <= addr_nxt;
			cnt_r <= cnt_nxt;
			mask_r <= mask_nxt;
			rf_stop_r <= rf_stop_nxt;
			srst_pend_r <= srst_pend_nxt;
			res_r <= res_nxt;
			flags_r <= flags_nxt;
			irq_n_r <= irq_n_nxt;
			rd_act_r <= rd_act_nxt;
			resp0_r <= resp0_nxt;
			resp1_r <= resp1_nxt;
			resp_two_r <= resp_two_nxt;
			srst_cnt_r <= srst_cnt_nxt;
			cfg_err_r <= cfg_err_nxt;
			bcc_err_r <= bcc_err_nxt;
			mem_we_r <= mem_we_nxt;
			mem_addr_r <= mem_addr_nxt;
			mem_wdata_r <= mem_wdata_nxt;
			nvm_reload_r <= nvm_reload_nxt;
		end
	end

	// outputs straight from flops
	assign lnk_tx_byte = tx_byte_r;
	assign irq_out_n = irq_n_r;
	assign irq_mask = mask_r;
	assign rf_stop = rf_stop_r;
	assign nvm_reload = nvm_reload_r;
	assign mem_we = mem_we_r;
	assign mem_addr = mem_addr_r;
	assign mem_wdata = mem_wdata_r;

	// checks on the core clock
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_cmd_write;
		rx_evt && st_r == hmc_pkg::ST_CMD && rx_hold_r == hmc_pkg::CMD_WRITE
			|=> st_r == hmc_pkg::ST_ADDR_H ##3 st_r != hmc_pkg::ST_CMD || !$past(rx_evt, 2);
	endproperty
	a_cmd_write: assert property (p_cmd_write) else $error("write code not decoded");

	property p_wr_data;
		rx_evt && st_r == hmc_pkg::ST_DATA |=> mem_we_r && mem_wdata_r == $past(rx_hold_r);
	endproperty
	a_wr_data: assert property (p_wr_data) else $error("payload byte not written");

	property p_len_range;
		rx_evt && st_r == hmc_pkg::ST_LEN && (rx_hold_r == 8'h00 || rx_hold_r > 8'hFB)
			|=> res_r == hmc_pkg::RES_PARAM && !irq_n_r && st_r == hmc_pkg::ST_CMD;
	endproperty
	a_len_range: assert property (p_len_range) else $error("bad length not refused");

	property p_ctrl_rd;
		rx_evt && st_r == hmc_pkg::ST_CMD && rx_hold_r == hmc_pkg::CMD_CTRL_RD
			|=> resp1_r[7:3] == {$past(mask_r), $past(rf_stop_r)} && !resp1_r[2] && resp_two_r;
	endproperty
	a_ctrl_rd: assert property (p_ctrl_rd) else $error("control read byte wrong");

	property p_ctl_wr;
		rx_evt && st_r == hmc_pkg::ST_CTL
			|=> mask_r == $past(rx_hold_r[7:4]) && rf_stop == $past(rx_hold_r[3]);
	endproperty
	a_ctl_wr: assert property (p_ctl_wr) else $error("control write not stored");

	property p_mask_wr;
		mask_r[3] && !flags_r[3] && !rd_evt |=> !flags_r[3];
	endproperty
	a_mask_wr: assert property (p_mask_wr) else $error("masked write flag set");

	property p_irq_release;
		rd_evt && !rx_evt |=> irq_out_n;
	endproperty
	a_irq_release: assert property (p_irq_release) else $error("interrupt not released");

	property p_srst_start;
		$rose(st_r == hmc_pkg::ST_SRST) |-> $past(stp_evt) && $past(rd_act_r);
	endproperty
	a_srst_start: assert property (p_srst_start) else $error("self-reset before reply");

	property p_srst_busy;
		st_r == hmc_pkg::ST_SRST && !rd_act_r |=> resp0_r[3:0] == hmc_pkg::RES_BUSY;
	endproperty
	a_srst_busy: assert property (p_srst_busy) else $error("no busy during self-reset");

endmodule : hmc_host_cmd

// File: testbench/hmc_host_model.sv
module hmc_host_model (
	// link clock
	input wire logic link_clk,
	// requests towards the decoder
	output logic lnk_rx_stb,
	output logic [7:0] lnk_rx_byte,
	output logic lnk_rd_req,
	output logic lnk_tx_ack,
	output logic lnk_stop,
	// byte offered by the decoder
	input wire logic [7:0] lnk_tx_byte
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle levels at time zero
	initial begin
		{lnk_rx_stb, lnk_rd_req, lnk_tx_ack, lnk_stop} = 4'h0;
		lnk_rx_byte = 8'h00;
	end

	// quiet spacing, data line never keeps a stale byte
	task automatic gap();
		repeat (30) begin
			@(posedge link_clk);
			lnk_rx_byte <= ~lnk_rx_byte;
		end
	endtask : gap

	// one received command byte
	task automatic send_byte(input logic [7:0] b);
		@(posedge link_clk);
		lnk_rx_stb <= 1'b1;
		lnk_rx_byte <= b;
		@(posedge link_clk);
		lnk_rx_stb <= 1'b0;
		lnk_rx_byte <= ~b;
		gap();
	endtask : send_byte

	// read request, n bytes taken, idle byte sampled, then stop
	task automatic read_reply(input int n, output logic [7:0] r[3]);
		@(posedge link_clk);
		lnk_rd_req <= 1'b1;
		@(posedge link_clk);
		lnk_rd_req <= 1'b0;
		for (int i = 0; i <= n; i++) begin
			repeat (2) @(posedge link_clk);
			r[i] = lnk_tx_byte;
			if (i < n) begin
				lnk_tx_ack <= 1'b1;
				@(posedge link_clk);
				lnk_tx_ack <= 1'b0;
			end
		end
		@(posedge link_clk);
		lnk_stop <= 1'b1;
		@(posedge link_clk);
		lnk_stop <= 1'b0;
		gap();
	endtask : read_reply
endmodule : hmc_host_model

// File: testbench/hmc_host_cmd_tb.sv
module hmc_host_cmd_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SRST = 20;
	logic clk, rst, link_clk, cfg, bcc, stb, rd, ack, stp;
	logic irq_out_n, rf_stop, nvm_reload, mem_we;
	logic [3:0] evt, irq_mask;
	logic [7:0] rxb, txb, mem_wdata;
	logic [15:0] mem_addr;
	logic [7:0] r[3];
	logic [23:0] wq[$];
	logic [31:0] seed = 32'h00016C1B;
	int failures = 0;
	int cmp_count = 0;
	int nvm_seen = 0;

	hmc_host_cmd #(.SRST_CYCLES(SRST)) i_dut (
		.clk(clk), .rst(rst), .link_clk(link_clk), .lnk_rx_stb(stb), .lnk_rx_byte(rxb),
		.lnk_rd_req(rd), .lnk_tx_ack(ack), .lnk_stop(stp), .lnk_tx_byte(txb),
		.rf_wr_evt(evt[3]), .rf_rd_evt(evt[2]), .rf_tx_evt(evt[1]), .fld_det_evt(evt[0]),
		.chk_cfg_err(cfg), .chk_bcc_err(bcc), .irq_out_n(irq_out_n), .irq_mask(irq_mask),
		.rf_stop(rf_stop), .nvm_reload(nvm_reload), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata)
	);
	hmc_host_model m (
		.link_clk(link_clk), .lnk_rx_stb(stb), .lnk_rx_byte(rxb), .lnk_rd_req(rd),
		.lnk_tx_ack(ack), .lnk_stop(stp), .lnk_tx_byte(txb)
	);

	// core clock and unrelated link clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		link_clk = 1'b0;
		#3;
		forever #6 link_clk = ~link_clk;
	end

	// record memory writes and reload pulses
	always @(posedge clk) begin
		if (mem_we === 1'b1)
			wq.push_back({mem_addr, mem_wdata});
		if (nvm_reload === 1'b1)
			nvm_seen++;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task automatic check(input logic [23:0] got, input logic [23:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : final_report

	// send a command, await the interrupt, read n reply bytes
	task automatic cmd(input logic [7:0] b[$], input int n);
		foreach (b[i])
			m.send_byte(b[i]);
		for (int k = 0; k < 60 && irq_out_n !== 1'b0; k++)
			@(posedge clk);
		check(irq_out_n, 1'b0);
		m.read_reply(n, r);
		check(irq_out_n, 1'b1);
	endtask : cmd

	task automatic ctlw(input logic [7:0] w);
		cmd({8'h78, w}, 1);
		check(r[0], 8'h05);
		check(r[1], 8'hFF);
		check({irq_mask, rf_stop}, w[7:3]);
	endtask : ctlw

	// expected control-read data: masks and rf-stop as written, bit 2 zero, check bits
	function automatic logic [7:0] exp_ctl(input logic [7:0] w, input logic c, input logic b);
		return {w[7:3], 1'b0, c, b};
	endfunction : exp_ctl

	task automatic ctlr(input logic [7:0] w);
		cmd({8'h68}, 2);
		check(r[0], 8'h05);
		check(r[1], exp_ctl(w, cfg, bcc));
		check(r[2], 8'hFF);
	endtask : ctlr

	// hang guard
	initial begin
		#1000000;
		failures++;
		$display("watchdog expired");
		final_report();
	end

	initial begin
		logic [7:0] w;
		logic [31:0] v;
		logic [15:0] a;
		logic [7:0] q[$];
		int n;
		rst = 1'b1;
		evt = 4'h0;
		cfg = 1'b1;
		bcc = 1'b0;
		repeat (4) @(posedge clk);
		check({irq_out_n, irq_mask, rf_stop, txb}, 14'h20FF);
		rst <= 1'b0;
		repeat (SRST + 6) @(posedge clk);
		m.read_reply(1, r);
		check({r[0], r[1]}, 16'h00FF);
		$display("test reset done");
		for (int i = 0; i < 6; i++) begin
			v = rnd();
			w = (i == 0) ? 8'hF0 : {v[7:4], 4'h0};
			ctlw(w);
			ctlr(w);
		end
		$display("test control done");
		for (int j = 0; j < 3; j++) begin
			v = rnd();
			w = (j == 0) ? 8'h00 : (j == 1) ? 8'hF0 : {v[7:4], 4'h0};
			ctlw(w);
			@(posedge clk);
			evt <= 4'hF;
			@(posedge clk);
			evt <= 4'h0;
			repeat (8) @(posedge clk);
			m.read_reply(1, r);
			check(r[0] & 8'hF0, {~w[7:4], 4'h0});
			m.read_reply(1, r);
			check(r[0] & 8'hF0, 8'h00);
		end
		$display("test flags done");
		for (int j = 0; j < 3; j++) begin
			v = rnd();
			n = (j == 0) ? 1 : (j == 1) ? 251 : 2 + v[3:0];
			a = v[31:16];
			q = {8'h18, a[15:8], a[7:0], 8'(n)};
			for (int k = 0; k < n; k++) begin
				v = rnd();
				q.push_back(v[7:0]);
			end
			wq.delete();
			cmd(q, 1);
			check({r[0], r[1]}, 16'h05FF);
			check(wq.size(), n);
			for (int k = 0; k < n && k < wq.size(); k++)
				check(wq[k], {16'(a + k), q[4 + k]});
		end
		$display("test memory write done");
		for (int j = 0; j < 3; j++) begin
			if (j == 2)
				q = {8'h33};
			else
				q = {8'h18, 8'h00, 8'h10, (j == 0) ? 8'h00 : 8'hFC};
			wq.delete();
			cmd(q, 1);
			check(r[0], (j == 2) ? 8'h08 : 8'h0A);
			check(wq.size(), 0);
		end
		$display("test refusals done");
		ctlw(8'h08);
		ctlr(8'h08);
		cfg <= 1'b0;
		bcc <= 1'b1;
		nvm_seen = 0;
		ctlw(8'h01);
		check(nvm_seen, 1);
		m.read_reply(1, r);
		check(r[0] & 8'h0F, 8'h07);
		repeat (SRST + 10) @(posedge clk);
		ctlr(8'h00);
		$display("test self reset done");
		final_report();
	end
endmodule : hmc_host_cmd_tb
